/* File: core/dma_error_log_and_crc_control.sv */
// DMA bus error log and CRC control with an APB register slave.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module dma_error_log_and_crc_control
   import dma_error_crc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rdErr,
   input wire logic [CH_W-1:0] rdErrChan,
   input wire logic [31:0] rdErrAddr,
   input wire logic wrErr,
   input wire logic [CH_W-1:0] wrErrChan,
   input wire logic [31:0] wrErrAddr,
   input wire logic inValid,
   input wire logic [CH_W-1:0] inChan,
   input wire logic [31:0] inData,
   output logic outValid,
   output logic [31:0] outData,
   input wire logic blockDone,
   input wire logic [CH_W-1:0] blockChan,
   input wire logic [31:0] destStart,
   output logic storeValid,
   output logic [31:0] storeAddr,
   output logic [31:0] storeData
);
   // -------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------
   logic rstMeta_reg;
   logic rstN_reg;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_reg <= 1'b0;
         rstN_reg <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstN_reg <= rstMeta_reg;
      end
   end

   // -------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------
   function automatic logic [31:0] reorder(input logic [31:0] d,
                                           input logic [1:0] m);
      logic [31:0] r;
      r = d;
      unique case (m)
         BO_NONE: r = d;
         BO_WORD_SWAP: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
         BO_HALF_SWAP: r = {d[15:0], d[31:16]};
         BO_HALF_BYTE: r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      endcase
      return r;
   endfunction : reorder

   function automatic logic [31:0] lenMask(input logic [PLEN_W-1:0] p);
      logic [31:0] m;
      m = WORD_ZERO;
      for (int i = 0; i < CRC_MAX_W; i++)
         m[i] = (i <= int'(p));
      return m;
   endfunction : lenMask

   function automatic logic [31:0] lfsrWord(input logic [31:0] c,
                                            input logic [31:0] d,
                                            input logic [31:0] taps,
                                            input logic [PLEN_W-1:0] p,
                                            input logic refl);
      logic [31:0] s;
      logic [31:0] m;
      logic fb;
      s = c;
      m = lenMask(p);
      fb = 1'b0;
      for (int i = 0; i < CRC_MAX_W; i++)
      begin
         fb = (refl ? d[i] : d[CRC_MAX_W-1-i]) ^ s[p];
         s = ({s[30:0], 1'b0} ^ (taps & {CRC_MAX_W{fb}})) & m;
      end
      return s;
   endfunction : lfsrWord

   function automatic logic [15:0] onesAdd(input logic [15:0] a,
                                           input logic [15:0] b);
      logic [16:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[15:0] + {15'h0000, t[16]};
   endfunction : onesAdd

   function automatic logic [15:0] rev16(input logic [15:0] d);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < IP_W; i++)
         r[i] = d[IP_W-1-i];
      return r;
   endfunction : rev16

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   logic pready_reg;
   logic apbAccess;
   logic rdAccess;
   logic wrAccess;
   logic hitStatus;
   logic hitAddress;
   logic hitControl;
   logic hitValue;
   logic hitTap;
   logic statRead;
   logic addrRead;
   assign apbAccess = psel & penable & ~pready_reg;
   assign rdAccess = apbAccess & ~pwrite;
   assign wrAccess = apbAccess & pwrite;
   assign hitStatus = paddr == OFS_ERR_STATUS;
   assign hitAddress = paddr == OFS_ERR_ADDRESS;
   assign hitControl = paddr == OFS_CRC_CONTROL;
   assign hitValue = paddr == OFS_CRC_VALUE;
   assign hitTap = paddr == OFS_CRC_TAP;
   assign statRead = rdAccess & hitStatus;
   assign addrRead = rdAccess & hitAddress;

   // -------------------------------------------------------------
   // Error log
   // -------------------------------------------------------------
   logic statHeld_reg;
   logic addrHeld_reg;
   logic errDir_reg;
   logic [CH_W-1:0] errChan_reg;
   logic [31:0] errAddr_reg;
   logic anyErr;
   logic statTake;
   logic addrTake;
   assign anyErr = rdErr | wrErr;
   // A new error beats the clearing read in the same cycle.
   assign statTake = anyErr & (~statHeld_reg | statRead);
   assign addrTake = anyErr & (~addrHeld_reg | addrRead);

   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
      begin
         statHeld_reg <= 1'b0;
         errDir_reg <= 1'b0;
         errChan_reg <= CHAN_ZERO;
      end
      else if (statTake)
      begin
         statHeld_reg <= 1'b1;
         errDir_reg <= rdErr;
         errChan_reg <= rdErr ? rdErrChan : wrErrChan;
      end
      else if (statRead)
      begin
         statHeld_reg <= 1'b0;
         errDir_reg <= 1'b0;
         errChan_reg <= CHAN_ZERO;
      end
   end

   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
      begin
         addrHeld_reg <= 1'b0;
         errAddr_reg <= WORD_ZERO;
      end
      else if (addrTake)
      begin
         addrHeld_reg <= 1'b1;
         errAddr_reg <= rdErr ? rdErrAddr : wrErrAddr;
      end
      else if (addrRead)
      begin
         addrHeld_reg <= 1'b0;
         errAddr_reg <= WORD_ZERO;
      end
   end

   // -------------------------------------------------------------
   // CRC control register
   // -------------------------------------------------------------
   logic [1:0] byteOrd_reg;
   logic wbo_reg;
   logic bitRef_reg;
   logic [PLEN_W-1:0] plen_reg;
   logic crc_route_enable_reg;
   logic append_reg;
   logic typeSel_reg;
   logic [CH_W-1:0] crcChan_reg;
   logic [31:0] ctrlWord;
   assign ctrlWord = pwdata & CC_MASK;

   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
      begin
         byteOrd_reg <= BO_NONE;
         wbo_reg <= 1'b0;
         bitRef_reg <= 1'b0;
         plen_reg <= PLEN_ZERO;
         crc_route_enable_reg <= 1'b0;
         append_reg <= 1'b0;
         typeSel_reg <= 1'b0;
         crcChan_reg <= CHAN_ZERO;
      end
      else if (wrAccess && hitControl)
      begin
         byteOrd_reg <= ctrlWord[CC_BYTO_LSB+:2];
         wbo_reg <= ctrlWord[CC_WBO_BIT];
         bitRef_reg <= ctrlWord[CC_CRC_BIT_REFLECT_BIT];
         plen_reg <= ctrlWord[CC_PLEN_LSB+:PLEN_W];
         crc_route_enable_reg <= ctrlWord[CC_EN_BIT];
         // Append cannot be set while write reordering is on.
         append_reg <= ctrlWord[CC_APP_BIT] & ~ctrlWord[CC_WBO_BIT];
         typeSel_reg <= ctrlWord[CC_TYP_BIT];
         crcChan_reg <= ctrlWord[CC_CHAN_LSB+:CH_W];
      end
   end

   // -------------------------------------------------------------
   // CRC engine
   // -------------------------------------------------------------
   logic [31:0] crcVal_reg;
   logic [31:0] tap_reg;
   logic routed;
   logic [31:0] ordered;
   logic [31:0] lfsrNext;
   logic [15:0] ipLo;
   logic [15:0] ipHi;
   logic [15:0] ipNext;
   logic [31:0] crcRead;
   assign routed = inValid & crc_route_enable_reg & (inChan == crcChan_reg);
   assign ordered = reorder(inData, byteOrd_reg);
   assign lfsrNext = lfsrWord(crcVal_reg, ordered, tap_reg,
                              plen_reg, bitRef_reg);
   assign ipLo = bitRef_reg ? rev16(ordered[15:0]) : ordered[15:0];
   assign ipHi = bitRef_reg ? rev16(ordered[31:16]) : ordered[31:16];
   assign ipNext = onesAdd(onesAdd(crcVal_reg[15:0], ipHi), ipLo);
   // Length plays no part in checksum mode.
   assign crcRead = typeSel_reg ? {16'h0000, ~crcVal_reg[15:0]}
                                : crcVal_reg & lenMask(plen_reg);

   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
         tap_reg <= WORD_ZERO;
      else if (wrAccess && hitTap)
         tap_reg <= pwdata;
   end

   // A seed written by software wins over data in the same cycle.
   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
         crcVal_reg <= WORD_ZERO;
      else if (wrAccess && hitValue)
         crcVal_reg <= typeSel_reg ? {16'h0000, ~pwdata[15:0]}
                                   : pwdata;
      else if (routed && typeSel_reg)
         crcVal_reg <= {16'h0000, ipNext};
      else if (routed)
         crcVal_reg <= lfsrNext;
   end

   // -------------------------------------------------------------
   // Destination data path
   // -------------------------------------------------------------
   logic outValid_reg;
   logic [31:0] outData_reg;
   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
      begin
         outValid_reg <= 1'b0;
         outData_reg <= WORD_ZERO;
      end
      else
      begin
         outValid_reg <= inValid & ~(routed & append_reg);
         outData_reg <= (routed && wbo_reg) ? ordered : inData;
      end
   end

   logic storeValid_reg;
   logic [31:0] storeAddr_reg;
   logic [31:0] storeData_reg;
   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
      begin
         storeValid_reg <= 1'b0;
         storeAddr_reg <= WORD_ZERO;
         storeData_reg <= WORD_ZERO;
      end
      else
      begin
         storeValid_reg <= blockDone & crc_route_enable_reg & append_reg &
                           (blockChan == crcChan_reg);
         storeAddr_reg <= destStart;
         storeData_reg <= crcRead;
      end
   end

   // -------------------------------------------------------------
   // APB answer
   // -------------------------------------------------------------
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [31:0] readMux;
   logic hitAny;
   assign hitAny = hitStatus | hitAddress | hitControl | hitValue | hitTap;

   always_comb
   begin
      readMux = WORD_ZERO;
      if (hitStatus)
      begin
         readMux[ST_DIR_BIT] = errDir_reg;
         readMux[ST_CHAN_LSB+:CH_W] = errChan_reg;
      end
      else if (hitAddress)
         readMux = errAddr_reg;
      else if (hitControl)
      begin
         readMux[CC_BYTO_LSB+:2] = byteOrd_reg;
         readMux[CC_WBO_BIT] = wbo_reg;
         readMux[CC_CRC_BIT_REFLECT_BIT] = bitRef_reg;
         readMux[CC_PLEN_LSB+:PLEN_W] = plen_reg;
         readMux[CC_EN_BIT] = crc_route_enable_reg;
         readMux[CC_APP_BIT] = append_reg;
         readMux[CC_TYP_BIT] = typeSel_reg;
         readMux[CC_CHAN_LSB+:CH_W] = crcChan_reg;
      end
      else if (hitValue)
         readMux = crcRead;
      else if (hitTap)
         readMux = tap_reg;
   end

   always_ff @(posedge mclk or negedge rstN_reg)
   begin
      if (!rstN_reg)
      begin
         pready_reg <= 1'b0;
         prdata_reg <= WORD_ZERO;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= apbAccess;
         pslverr_reg <= apbAccess & ~hitAny;
         if (rdAccess)
            prdata_reg <= readMux;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign outValid = outValid_reg;
   assign outData = outData_reg;
   assign storeValid = storeValid_reg;
   assign storeAddr = storeAddr_reg;
   assign storeData = storeData_reg;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstN_reg);

   a_err_rd_wins: assert property (
      rdErr && wrErr && !statHeld_reg && !addrHeld_reg |=> errDir_reg &&
      errChan_reg == $past(rdErrChan) && errAddr_reg == $past(rdErrAddr))
      else $error("Read error not preferred.");
   a_err_wr_dir: assert property (
      wrErr && !rdErr && !statHeld_reg |=> !errDir_reg && statHeld_reg)
      else $error("Write error direction wrong.");
   a_err_addr_cap: assert property (
      wrErr && !rdErr && !addrHeld_reg |=>
      errAddr_reg == $past(wrErrAddr))
      else $error("Error address not captured.");
   a_err_hold: assert property (
      statHeld_reg && !statRead ##1 !statRead |=>
      $stable(errChan_reg) && $stable(errDir_reg))
      else $error("Held error record changed.");
   a_stat_clear: assert property (
      statRead && !anyErr |=> !statHeld_reg && errChan_reg == CHAN_ZERO &&
      pready && prdata[ST_CHAN_LSB+:CH_W] == $past(errChan_reg) &&
      prdata[ST_DIR_BIT] == $past(errDir_reg))
      else $error("Status read did not return then clear.");
   a_addr_clear: assert property (
      addrRead && !anyErr |=> errAddr_reg == WORD_ZERO)
      else $error("Address read did not clear.");
   a_append_block: assert property (
      wbo_reg |-> !append_reg)
      else $error("Append set with write reorder.");
   a_pass_plain: assert property (
      inValid && !routed |=> outValid && outData == $past(inData))
      else $error("Unrouted data altered.");
   a_ctrl_zero: assert property (
      rdAccess && hitControl |=> (prdata & ~CC_MASK) == WORD_ZERO)
      else $error("Reserved control bits read nonzero.");
   a_ip_upper: assert property (
      typeSel_reg && rdAccess && hitValue |=> prdata[31:16] == 16'h0000)
      else $error("Checksum upper half nonzero.");
   a_apb_ready: assert property (
      apbAccess |=> pready && !apbAccess ##1 !pready)
      else $error("Ready not a single pulse.");
endmodule : dma_error_log_and_crc_control

/* File: inc/dma_error_crc_pkg.sv */
// Constants shared by the DMA error log and CRC control block.
package dma_error_crc_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] OFS_ERR_STATUS = 8'h00;
   localparam logic [APB_AW-1:0] OFS_ERR_ADDRESS = 8'h04;
   localparam logic [APB_AW-1:0] OFS_CRC_CONTROL = 8'h08;
   localparam logic [APB_AW-1:0] OFS_CRC_VALUE = 8'h0c;
   localparam logic [APB_AW-1:0] OFS_CRC_TAP = 8'h10;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int ST_DIR_BIT = 31;
   localparam int ST_CHAN_LSB = 0;
   localparam int CH_W = 3;
   localparam int CC_BYTO_LSB = 28;
   localparam int CC_WBO_BIT = 27;
   localparam int CC_CRC_BIT_REFLECT_BIT = 24;
   localparam int CC_PLEN_LSB = 8;
   localparam int PLEN_W = 5;
   localparam int CC_EN_BIT = 7;
   localparam int CC_APP_BIT = 6;
   localparam int CC_TYP_BIT = 5;
   localparam int CC_CHAN_LSB = 0;
   localparam logic [31:0] CC_MASK = 32'h3900_1fe7;
   // -------------------------------------------------------------
   // Byte order codes and reset values
   // -------------------------------------------------------------
   localparam logic [1:0] BO_NONE = 2'h0;
   localparam logic [1:0] BO_WORD_SWAP = 2'h1;
   localparam logic [1:0] BO_HALF_SWAP = 2'h2;
   localparam logic [1:0] BO_HALF_BYTE = 2'h3;
   localparam int CRC_MAX_W = 32;
   localparam int IP_W = 16;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [CH_W-1:0] CHAN_ZERO = 3'h0;
   localparam logic [PLEN_W-1:0] PLEN_ZERO = 5'h00;
endpackage : dma_error_crc_pkg

/* File: verification/bus_partner.sv */
// Model of the system data bus facing the error log and CRC block.
`timescale 1ns/1ps
module bus_partner
   import dma_error_crc_pkg::*;
(
   input wire logic mclk,
   output logic rdErr,
   output logic [CH_W-1:0] rdErrChan,
   output logic [31:0] rdErrAddr,
   output logic wrErr,
   output logic [CH_W-1:0] wrErrChan,
   output logic [31:0] wrErrAddr,
   output logic inValid,
   output logic [CH_W-1:0] inChan,
   output logic [31:0] inData,
   output logic blockDone,
   output logic [CH_W-1:0] blockChan,
   output logic [31:0] destStart,
   input wire logic outValid,
   input wire logic [31:0] outData,
   input wire logic storeValid,
   input wire logic [31:0] storeAddr,
   input wire logic [31:0] storeData
);
   int nOut = 0;
   int nStore = 0;
   logic [31:0] lastOut = '0;
   logic [31:0] lastAddr = '0;
   logic [31:0] lastStore = '0;

   initial
   begin
      {rdErr, rdErrChan, rdErrAddr, wrErr, wrErrChan, wrErrAddr} = '0;
      {inValid, inChan, inData, blockDone, blockChan, destStart} = '0;
   end

   // ---------------------------------------------------------------
   // Bus events
   // ---------------------------------------------------------------
   // Released address and data lines show the inverse of the last value.
   task automatic bus_error(input logic rd, input logic wr,
      input logic [2:0] rc, input logic [2:0] wc,
      input logic [31:0] ra, input logic [31:0] wa);
      @(posedge mclk);
      rdErr <= rd;
      wrErr <= wr;
      rdErrChan <= rc;
      wrErrChan <= wc;
      rdErrAddr <= ra;
      wrErrAddr <= wa;
      @(posedge mclk);
      rdErr <= 1'b0;
      wrErr <= 1'b0;
      rdErrAddr <= ~ra;
      wrErrAddr <= ~wa;
   endtask : bus_error

   // Only whole aligned words are ever sent.
   task automatic send_word(input logic [2:0] ch, input logic [31:0] d);
      @(posedge mclk);
      inValid <= 1'b1;
      inChan <= ch;
      inData <= d;
      @(posedge mclk);
      inValid <= 1'b0;
      inData <= ~d;
      repeat (2) @(posedge mclk);
   endtask : send_word

   task automatic end_block(input logic [2:0] ch, input logic [31:0] a);
      @(posedge mclk);
      blockDone <= 1'b1;
      blockChan <= ch;
      destStart <= a;
      @(posedge mclk);
      blockDone <= 1'b0;
      destStart <= ~a;
      repeat (2) @(posedge mclk);
   endtask : end_block

   always @(posedge mclk)
   begin
      if (outValid === 1'b1)
      begin
         nOut <= nOut + 1;
         lastOut <= outData;
      end
      if (storeValid === 1'b1)
      begin
         nStore <= nStore + 1;
         lastAddr <= storeAddr;
         lastStore <= storeData;
      end
   end
endmodule : bus_partner

/* File: verification/testbench.sv */
// Self-checking testbench for the DMA error log and CRC control block.
`timescale 1ns/1ps
module testbench
   import dma_error_crc_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rdErrAddr, wrErrAddr, inData, outData;
   logic [31:0] destStart, storeAddr, storeData;
   logic pready, pslverr, rdErr, wrErr, inValid, outValid;
   logic blockDone, storeValid;
   logic [CH_W-1:0] rdErrChan, wrErrChan, inChan, blockChan;
   int nErrors = 0;
   int nCompared = 0;
   int cycles = 0;
   int i;
   logic [31:0] rd, taps, exp;
   logic err, refl;
   logic [4:0] len;

   always #25 mclk = ~mclk;

   dma_error_log_and_crc_control uut (.mclk, .rst_b, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rdErr,
      .rdErrChan, .rdErrAddr, .wrErr, .wrErrChan, .wrErrAddr, .inValid,
      .inChan, .inData, .outValid, .outData, .blockDone, .blockChan,
      .destStart, .storeValid, .storeAddr, .storeData);

   bus_partner partner (.mclk, .rdErr, .rdErrChan, .rdErrAddr, .wrErr,
      .wrErrChan, .wrErrAddr, .inValid, .inChan, .inData, .blockDone,
      .blockChan, .destStart, .outValid, .outData, .storeValid,
      .storeAddr, .storeData);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      nCompared++;
      if (seen !== want)
      begin
         nErrors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic conclude;
      $display("compared %0d, mismatches %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
      input logic [31:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      // Waits as long as the slave needs; only the bench timeout ends it.
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wreg(input logic [APB_AW-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wreg

   task automatic rchk(input logic [APB_AW-1:0] a, input logic [31:0] e);
      apb(1'b0, a, WORD_ZERO);
      check(rd, e);
   endtask : rchk

   function automatic logic [31:0] ctl(input logic [1:0] bo,
      input logic write_reorder_select, input logic rf, input logic [4:0] pl,
      input logic en, input logic app, input logic typ, input logic [2:0] ch);
      return {2'h0, bo, write_reorder_select, 2'h0, rf, 11'h0, pl, en, app, typ, 2'h0, ch};
   endfunction : ctl

   function automatic logic [31:0] swap(input logic [1:0] bo,
      input logic [31:0] d);
      case (bo)
         BO_HALF_BYTE: return {d[23:16], d[31:24], d[7:0], d[15:8]};
         BO_HALF_SWAP: return {d[15:0], d[31:16]};
         BO_WORD_SWAP: return {d[7:0], d[15:8], d[23:16], d[31:24]};
         default: return d;
      endcase
   endfunction : swap

   function automatic logic [31:0] lfsr(input logic [31:0] s,
      input logic [31:0] d, input logic [31:0] t, input logic [4:0] pl,
      input logic rf);
      logic [31:0] m;
      logic fb;
      m = (pl == 5'h1f) ? 32'hffff_ffff : ((32'h1 << (pl + 1)) - 1);
      s = s & m;
      for (int b = 0; b < 32; b++)
      begin
         fb = (rf ? d[b] : d[31-b]) ^ s[pl];
         s = ((s << 1) ^ (t & {32{fb}})) & m;
      end
      return s;
   endfunction : lfsr

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         nErrors++;
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rchk(OFS_ERR_STATUS, WORD_ZERO);
      rchk(OFS_ERR_ADDRESS, WORD_ZERO);
      rchk(OFS_CRC_CONTROL, WORD_ZERO);
      rchk(OFS_CRC_VALUE, WORD_ZERO);
      rchk(OFS_CRC_TAP, WORD_ZERO);
      $display("test reset done");

      partner.bus_error(1, 1, 3'h6, 3'h2, 32'hdead_0010, 32'h0bad_0020);
      partner.bus_error(0, 1, 3'h1, 3'h4, 32'h1111_1111, 32'h2222_2224);
      wreg(OFS_ERR_STATUS, 32'hffff_ffff);
      rchk(OFS_ERR_STATUS, 32'h8000_0006);
      rchk(OFS_ERR_STATUS, WORD_ZERO);
      rchk(OFS_ERR_ADDRESS, 32'hdead_0010);
      rchk(OFS_ERR_ADDRESS, WORD_ZERO);
      partner.bus_error(0, 1, 3'h0, 3'h5, 32'h0, 32'h8765_8004);
      rchk(OFS_ERR_STATUS, 32'h0000_0005);
      rchk(OFS_ERR_ADDRESS, 32'h8765_8004);
      $display("test error log done");

      wreg(OFS_CRC_CONTROL, 32'hffff_ffff);
      rchk(OFS_CRC_CONTROL, CC_MASK & ~(32'h1 << CC_APP_BIT));
      wreg(OFS_CRC_CONTROL, CC_MASK & ~(32'h1 << CC_WBO_BIT));
      rchk(OFS_CRC_CONTROL, CC_MASK & ~(32'h1 << CC_WBO_BIT));
      apb(1'b0, 8'h14, WORD_ZERO);
      check({31'h0, err}, 32'h1);
      $display("test control done");

      for (i = 0; i < 4; i++)
      begin
         wreg(OFS_CRC_CONTROL, ctl(i[1:0], 1, 0, 5'h1f, 1, 0, 0, 3'h3));
         partner.send_word(3'h3, 32'h1122_3344);
         check(partner.lastOut, swap(i[1:0], 32'h1122_3344));
         partner.send_word(3'h2, 32'h5566_7788);
         check(partner.lastOut, 32'h5566_7788);
      end
      wreg(OFS_CRC_CONTROL, ctl(BO_WORD_SWAP, 0, 0, 5'h1f, 1, 0, 0, 3'h3));
      partner.send_word(3'h3, 32'h1122_3344);
      check(partner.lastOut, 32'h1122_3344);
      wreg(OFS_CRC_CONTROL, ctl(BO_WORD_SWAP, 1, 0, 5'h1f, 0, 0, 0, 3'h3));
      partner.send_word(3'h3, 32'h99aa_bbcc);
      check(partner.lastOut, 32'h99aa_bbcc);
      $display("test byte order done");

      for (i = 0; i < 4; i++)
      begin
         refl = i[0];
         len = i[1] ? 5'h1f : 5'h07;
         taps = i[1] ? 32'h04c1_1db7 : 32'h0000_0007;
         wreg(OFS_CRC_CONTROL, ctl(BO_NONE, 0, refl, len, 1, 0, 0, 3'h3));
         wreg(OFS_CRC_TAP, taps);
         wreg(OFS_CRC_VALUE, 32'hffff_ffff);
         partner.send_word(3'h2, 32'h0f0f_0f0f);
         partner.send_word(3'h3, 32'h3132_3334);
         exp = lfsr(32'hffff_ffff, 32'h3132_3334, taps, len, refl);
         rchk(OFS_CRC_VALUE, exp);
      end
      $display("test lfsr done");

      for (i = 0; i < 2; i++)
      begin
         wreg(OFS_CRC_CONTROL, ctl(BO_NONE, 0, i[0], 5'h07, 1, 0, 1, 3'h3));
         wreg(OFS_CRC_VALUE, 32'h0000_ffff);
         partner.send_word(3'h3, 32'hffff_0001);
         partner.send_word(3'h3, 32'h1234_5678);
         rchk(OFS_CRC_VALUE, i[0] ? 32'h0000_354d : 32'h0000_9752);
      end
      $display("test checksum done");

      wreg(OFS_CRC_CONTROL, ctl(BO_NONE, 0, 0, 5'h07, 1, 1, 0, 3'h1));
      wreg(OFS_CRC_TAP, 32'h0000_0007);
      wreg(OFS_CRC_VALUE, 32'h0000_00ab);
      partner.send_word(3'h1, 32'ha5a5_0f0f);
      partner.end_block(3'h1, 32'h2000_0100);
      check(partner.lastAddr, 32'h2000_0100);
      exp = lfsr(32'h0000_00ab, 32'ha5a5_0f0f, 32'h7, 5'h07, 1'b0);
      check(partner.lastStore, exp);
      check(32'(partner.nStore), 32'h1);
      check(32'(partner.nOut), 32'h16);
      $display("test append done");
      conclude();
   end
endmodule : testbench
